/* File: pkg/mad_params.svh */
`ifndef MAD_PARAMS_SVH
`define MAD_PARAMS_SVH

// register byte offsets on the AXI4-Lite slave
`define MAD_OFF_SYSTEM_CONTROL_REG  8'h00
`define MAD_OFF_STATUS  8'h04
`define MAD_OFF_ADDR    8'h08
`define MAD_OFF_WDATA   8'h0c
`define MAD_OFF_RDCMD   8'h10
`define MAD_OFF_RDATA   8'h14
`define MAD_OFF_FLAGS   8'h18
`define MAD_OFF_FLAGIN  8'h1c

// system_control_reg fields, its writable mask and reset value
`define MAD_BIT_PORTEN  0
`define MAD_BIT_WIDE    1
`define MAD_BIT_FLAGEN  20
`define MAD_SYSTEM_CONTROL_REG_MASK 32'h0010_0003
`define MAD_RST_SYSTEM_CONTROL_REG  32'h0000_0000
`define MAD_RST_FLAGS   32'h0000_0000

// axi responses
`define MAD_RESP_OKAY   2'h0
`define MAD_RESP_SLVERR 2'h2

// core-to-input clock multiples per strap code, zero for the reserved code
`define MAD_RATIO_00    5'h03
`define MAD_RATIO_01    5'h10
`define MAD_RATIO_10    5'h08
`define MAD_RATIO_11    5'h00

// timing: clock period, address and strobe phase times in ns
`define MAD_CLK_NS      10
`define MAD_ALE_NS      20
`define MAD_STB_NS      30

// input clock cycles to wait for lock after reset
`define MAD_PLL_LOCK    4096

`endif

/* File: pkg/mad_pkg.sv */
package mad_pkg;

   // boot source, in strap code order
   typedef enum logic [1:0] {
      MAD_BOOT_SPI_SLAVE,
      MAD_BOOT_SPI_MASTER,
      MAD_BOOT_PAR_EPROM,
      MAD_BOOT_RESERVED
   } mad_boot_t;

   // parallel port cycle engine
   typedef enum logic [1:0] {
      MAD_IDLE,
      MAD_ADDR,
      MAD_DATA
   } mad_state_t;

endpackage

/* File: pkg/mad_stream_if.sv */
`timescale 1ns/100ps
// one valid/ready word stream between the port and its fifo
interface mad_stream_if #(
   parameter int W = 16
);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

/* File: rtl/mad_fifo.sv */
`timescale 1ns/100ps
module mad_fifo #(
   parameter int W     = 16,
   parameter int DEPTH = 16
) (
   input logic         clk_sys,
   input logic         rst,
   mad_stream_if.snk   inS,
   mad_stream_if.src   outS
);
   localparam int AW = $clog2(DEPTH);

   // power of two depth keeps the wrap bit trick honest
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
      $error("mad_fifo: DEPTH must be a power of two, at least 2");
   end

   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wp_q;
   logic [AW:0]  rp_q;

   // full when pointers differ only in the wrap bit
   wire full  = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
   wire empty = (wp_q == rp_q);
   wire push  = inS.valid & ~full;
   wire pop   = outS.ready & ~empty;

   assign inS.ready  = ~full;
   assign outS.valid = ~empty;
   assign outS.data  = mem[rp_q[AW-1:0]];

   // storage has no reset, only pointers need a defined value
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wp_q[AW-1:0]] <= inS.data;
      end
   end

   // pointers
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wp_q <= '0;
         rp_q <= '0;
      end else begin
         if (push) begin
            wp_q <= wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= rp_q + 1'b1;
         end
      end
   end
endmodule

/* File: rtl/mad_port.sv */
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`include "mad_params.svh"
module mad_port #(
   parameter int ADDR_W     = 8,
   parameter int PLL_LOCK   = `MAD_PLL_LOCK,
   parameter int FIFO_DEPTH = 16
) (
   input  logic              clk_sys,
   input  logic              rst,
   input  logic [ADDR_W-1:0] awaddr,
   input  logic              awvalid,
   output logic              awready,
   input  logic [31:0]       wdata,
   input  logic [3:0]        wstrb,
   input  logic              wvalid,
   output logic              wready,
   output logic [1:0]        bresp,
   output logic              bvalid,
   input  logic              bready,
   input  logic [ADDR_W-1:0] araddr,
   input  logic              arvalid,
   output logic              arready,
   output logic [31:0]       rdata,
   output logic [1:0]        rresp,
   output logic              rvalid,
   input  logic              rready,
   input  logic [15:0]       adIn,
   output logic [15:0]       adOut,
   output logic [15:0]       adOe,
   output logic              aleOut,
   output logic              rdN,
   output logic              wrN,
   input  logic [1:0]        bootSelectStraps,
   input  logic [1:0]        clockRatioStraps,
   input  logic              inputClockPin,
   output logic [1:0]        bootMode,
   output logic [4:0]        coreRatio,
   output logic              coreRun
);
   localparam int ALE_CYC = (`MAD_ALE_NS + `MAD_CLK_NS - 1) / `MAD_CLK_NS;
   localparam int STB_CYC = (`MAD_STB_NS + `MAD_CLK_NS - 1) / `MAD_CLK_NS;
   localparam logic [3:0] ALE_LAST = 4'(ALE_CYC - 1);
   localparam logic [3:0] STB_LAST = 4'(STB_CYC - 1);

   // refuse shapes the decode or counters cannot serve
   if (ADDR_W < 5 || ADDR_W > 32 || PLL_LOCK < 1 || STB_CYC > 16) begin : g_chk
      $error("mad_port: unsupported parameter value");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state

   logic [31:0]             system_control_reg_q;
   logic [23:0]             addr_q;
   logic [31:0]             flags_q;
   logic [15:0]             rdData_q;
   logic                    rdReq_q;
   mad_pkg::mad_state_t     state_q;
   logic [3:0]              cnt_q;
   logic                    wrOp_q;
   logic                    wideOp_q;
   logic [15:0]             wdat_q;
   logic [15:0]             adOut_q;
   logic [15:0]             adOe_q;
   logic                    ale_q;
   logic                    rdN_q;
   logic                    wrN_q;
   logic                    capt_q;
   logic [1:0]              bootStr_q;
   logic [1:0]              ratioStr_q;
   logic                    inClk_q;
   logic [31:0]             lockCnt_q;
   logic                    pllDone_q;
   logic                    awHeld_q;
   logic [ADDR_W-1:0]       awAddr_q;
   logic                    wHeld_q;
   logic [31:0]             wData_q;
   logic [3:0]              wStrb_q;
   logic                    bvalid_q;
   logic [1:0]              bresp_q;
   logic                    rvalid_q;
   logic [31:0]             rdata_q;
   logic [1:0]              rresp_q;

   mad_stream_if #(.W(16)) pushS ();
   mad_stream_if #(.W(16)) popS ();

   ////////////////////////////////////////////////////////////////////////////////
   // write data fifo: full fifo holds off the axi write

   mad_fifo #(
      .W     (16),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_sys (clk_sys),
      .rst     (rst),
      .inS     (pushS),
      .outS    (popS)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // axi write decode

   wire [ADDR_W-1:0] wA      = {awAddr_q[ADDR_W-1:2], 2'b00};
   wire              wSysctl = (wA == ADDR_W'(`MAD_OFF_SYSTEM_CONTROL_REG));
   wire              wStatus = (wA == ADDR_W'(`MAD_OFF_STATUS));
   wire              wAddr   = (wA == ADDR_W'(`MAD_OFF_ADDR));
   wire              wWdata  = (wA == ADDR_W'(`MAD_OFF_WDATA));
   wire              wRdcmd  = (wA == ADDR_W'(`MAD_OFF_RDCMD));
   wire              wRdata  = (wA == ADDR_W'(`MAD_OFF_RDATA));
   wire              wFlags  = (wA == ADDR_W'(`MAD_OFF_FLAGS));
   wire              wFlagin = (wA == ADDR_W'(`MAD_OFF_FLAGIN));
   wire              wMapped = wSysctl | wStatus | wAddr | wWdata | wRdcmd
                               | wRdata | wFlags | wFlagin;
   wire              bothIn  = awHeld_q & wHeld_q & ~bvalid_q;
   // a data word waits here while the fifo is full
   wire              doWrite = bothIn & (~wWdata | pushS.ready);
   wire [31:0]       wMerged = mergeBytes(32'h0000_0000, wData_q, wStrb_q);

   assign awready     = ~awHeld_q & ~bvalid_q;
   assign wready      = ~wHeld_q & ~bvalid_q;
   assign bvalid      = bvalid_q;
   assign bresp       = bresp_q;
   assign pushS.valid = bothIn & wWdata;
   assign pushS.data  = wData_q[15:0];

   function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction

   // address and data phases are held until both are in
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         awHeld_q <= 1'b0;
         awAddr_q <= '0;
         wHeld_q  <= 1'b0;
         wData_q  <= 32'h0000_0000;
         wStrb_q  <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            awHeld_q <= 1'b1;
            awAddr_q <= awaddr;
         end else if (doWrite) begin
            awHeld_q <= 1'b0;
         end
         if (wvalid && wready) begin
            wHeld_q <= 1'b1;
            wData_q <= wdata;
            wStrb_q <= wstrb;
         end else if (doWrite) begin
            wHeld_q <= 1'b0;
         end
      end
   end

   // write response
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         bvalid_q <= 1'b0;
         bresp_q  <= `MAD_RESP_OKAY;
      end else if (doWrite) begin
         bvalid_q <= 1'b1;
         bresp_q  <= wMapped ? `MAD_RESP_OKAY : `MAD_RESP_SLVERR;
      end else if (bready) begin
         bvalid_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // engine control terms

   wire flagMode = system_control_reg_q[`MAD_BIT_FLAGEN] & ~system_control_reg_q[`MAD_BIT_PORTEN];
   wire portOn   = system_control_reg_q[`MAD_BIT_PORTEN] & pllDone_q;
   wire isIdle   = (state_q == mad_pkg::MAD_IDLE);
   wire startWr  = isIdle & portOn & popS.valid;
   // queued writes go first so a read sees them on the bus
   wire startRd  = isIdle & portOn & ~popS.valid & rdReq_q;
   wire lastData = (state_q == mad_pkg::MAD_DATA) && (cnt_q == 4'h0);

   assign popS.ready = startWr;

   // software registers; address writes during a transfer are dropped
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         system_control_reg_q <= `MAD_RST_SYSTEM_CONTROL_REG;
         addr_q   <= 24'h00_0000;
         flags_q  <= `MAD_RST_FLAGS;
         rdReq_q  <= 1'b0;
      end else begin
         if (doWrite && wSysctl) begin
            system_control_reg_q <= mergeBytes(system_control_reg_q, wData_q, wStrb_q) & `MAD_SYSTEM_CONTROL_REG_MASK;
         end
         if (doWrite && wAddr && isIdle) begin
            addr_q <= 24'(mergeBytes({8'h00, addr_q}, wData_q, wStrb_q));
         end else if (lastData) begin
            addr_q <= addr_q + 24'h00_0001;
         end
         if (doWrite && wFlags) begin
            flags_q <= mergeBytes(flags_q, wData_q, wStrb_q);
         end
         // a new request in the taking cycle survives
         rdReq_q <= (doWrite & wRdcmd & wMerged[0]) | (rdReq_q & ~startRd);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // address/data cycle engine

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q  <= mad_pkg::MAD_IDLE;
         cnt_q    <= 4'h0;
         wrOp_q   <= 1'b0;
         wideOp_q <= 1'b0;
         wdat_q   <= 16'h0000;
         rdData_q <= 16'h0000;
      end else begin
         case (state_q)
            mad_pkg::MAD_IDLE: begin
               if (startWr || startRd) begin
                  state_q  <= mad_pkg::MAD_ADDR;
                  cnt_q    <= ALE_LAST;
                  wrOp_q   <= startWr;
                  wideOp_q <= system_control_reg_q[`MAD_BIT_WIDE];
                  wdat_q   <= popS.data;
               end
            end
            mad_pkg::MAD_ADDR: begin
               if (cnt_q == 4'h0) begin
                  state_q <= mad_pkg::MAD_DATA;
                  cnt_q   <= STB_LAST;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            mad_pkg::MAD_DATA: begin
               if (cnt_q == 4'h0) begin
                  state_q <= mad_pkg::MAD_IDLE;
                  if (!wrOp_q) begin
                     rdData_q <= wideOp_q ? adIn : {8'h00, adIn[7:0]};
                  end
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            default: begin
               state_q <= mad_pkg::MAD_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pin multiplexing

   logic [15:0] flagPinVal;
   logic [15:0] flagPinOe;
   logic [15:0] flagInView;

   // each pin swaps byte halves to reach its flag
   for (genvar i = 0; i < 16; i++) begin : g_flag
      localparam int F = (i < 8) ? i + 8 : i - 8;
      assign flagPinVal[i] = flags_q[F];
      assign flagPinOe[i]  = flags_q[16 + F];
      assign flagInView[F] = adIn[i];
   end

   wire inAddr = (state_q == mad_pkg::MAD_ADDR);
   wire inData = (state_q == mad_pkg::MAD_DATA);
   // 8-bit: {A23-16, A15-8}; 16-bit: A15-0
   wire [15:0] pinAddr = wideOp_q ? addr_q[15:0] : addr_q[23:8];
   // 8-bit: upper byte keeps address A7-0 during data
   wire [15:0] pinData = wideOp_q ? wdat_q : {addr_q[7:0], wdat_q[7:0]};
   wire [15:0] dataOe  = wrOp_q ? 16'hffff : (wideOp_q ? 16'h0000 : 16'hff00);
   wire [15:0] adOutD  = inAddr ? pinAddr : inData ? pinData
                         : flagMode ? flagPinVal : 16'h0000;
   wire [15:0] adOeD   = inAddr ? 16'hffff : inData ? dataOe
                         : flagMode ? flagPinOe : 16'h0000;

   // pins leave from flops, one cycle behind the engine
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         adOut_q <= 16'h0000;
         adOe_q  <= 16'h0000;
         ale_q   <= 1'b0;
         rdN_q   <= 1'b1;
         wrN_q   <= 1'b1;
      end else begin
         adOut_q <= adOutD;
         adOe_q  <= adOeD;
         ale_q   <= inAddr;
         rdN_q   <= ~(inData & ~wrOp_q);
         wrN_q   <= ~(inData & wrOp_q);
      end
   end

   // strobes have no enable: always driven
   assign adOut  = adOut_q;
   assign adOe   = adOe_q;
   assign aleOut = ale_q;
   assign rdN    = rdN_q;
   assign wrN    = wrN_q;

   ////////////////////////////////////////////////////////////////////////////////
   // straps and lock wait

   // straps are caught on the first edge after reset release
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         capt_q     <= 1'b0;
         bootStr_q  <= 2'h0;
         ratioStr_q <= 2'h0;
      end else if (!capt_q) begin
         capt_q     <= 1'b1;
         bootStr_q  <= bootSelectStraps;
         ratioStr_q <= clockRatioStraps;
      end
   end

   assign bootMode  = mad_pkg::mad_boot_t'(bootStr_q);
   assign coreRatio = (ratioStr_q == 2'h0) ? `MAD_RATIO_00
                    : (ratioStr_q == 2'h1) ? `MAD_RATIO_01
                    : (ratioStr_q == 2'h2) ? `MAD_RATIO_10 : `MAD_RATIO_11;

   wire inRise = inputClockPin & ~inClk_q;

   // count input clock rising edges until lock
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         inClk_q   <= 1'b0;
         lockCnt_q <= 32'h0000_0000;
         pllDone_q <= 1'b0;
      end else begin
         inClk_q <= inputClockPin;
         if (inRise && !pllDone_q) begin
            lockCnt_q <= lockCnt_q + 32'h0000_0001;
            pllDone_q <= (lockCnt_q == 32'(PLL_LOCK - 1));
         end
      end
   end

   assign coreRun = pllDone_q;

   ////////////////////////////////////////////////////////////////////////////////
   // axi read

   wire [ADDR_W-1:0] rA = {araddr[ADDR_W-1:2], 2'b00};
   wire [31:0] statusWord = {20'h0_0000, ~pushS.ready, ~popS.valid, rdReq_q,
                             ~isIdle, pllDone_q, coreRatio, bootStr_q};
   wire rHit = (rA == ADDR_W'(`MAD_OFF_SYSTEM_CONTROL_REG)) | (rA == ADDR_W'(`MAD_OFF_STATUS))
             | (rA == ADDR_W'(`MAD_OFF_ADDR)) | (rA == ADDR_W'(`MAD_OFF_WDATA))
             | (rA == ADDR_W'(`MAD_OFF_RDCMD)) | (rA == ADDR_W'(`MAD_OFF_RDATA))
             | (rA == ADDR_W'(`MAD_OFF_FLAGS)) | (rA == ADDR_W'(`MAD_OFF_FLAGIN));
   wire [31:0] rMux =
        (rA == ADDR_W'(`MAD_OFF_SYSTEM_CONTROL_REG)) ? system_control_reg_q
      : (rA == ADDR_W'(`MAD_OFF_STATUS)) ? statusWord
      : (rA == ADDR_W'(`MAD_OFF_ADDR))   ? {8'h00, addr_q}
      : (rA == ADDR_W'(`MAD_OFF_RDCMD))  ? {31'h0000_0000, rdReq_q}
      : (rA == ADDR_W'(`MAD_OFF_RDATA))  ? {16'h0000, rdData_q}
      : (rA == ADDR_W'(`MAD_OFF_FLAGS))  ? flags_q
      : (rA == ADDR_W'(`MAD_OFF_FLAGIN)) ? {16'h0000, flagInView}
      : 32'h0000_0000;

   assign arready = ~rvalid_q;
   assign rvalid  = rvalid_q;
   assign rdata   = rdata_q;
   assign rresp   = rresp_q;

   // one read in flight; answer the cycle after the address is taken
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= `MAD_RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rMux;
         rresp_q  <= rHit ? `MAD_RESP_OKAY : `MAD_RESP_SLVERR;
      end else if (rready) begin
         rvalid_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence sAddrEnd;
      inAddr && (cnt_q == 4'h0);
   endsequence

   sequence sStrobeRun;
      inData [*3];
   endsequence

   a_flag_gate: assert property (isIdle && !flagMode |=> adOe == 16'h0000)
      else $error("pins driven while idle outside flag mode");
   a_flag_swap: assert property (isIdle && flagMode |=>
      adOut == {$past(flags_q[7:0]), $past(flags_q[15:8])})
      else $error("flag to pin mapping wrong");
   a_boot_code: assert property (capt_q && bootStr_q == 2'h2 |->
      bootMode == mad_pkg::MAD_BOOT_PAR_EPROM)
      else $error("boot strap decode wrong");
   a_ratio_code: assert property (capt_q && ratioStr_q == 2'h1 |-> coreRatio == 5'h10)
      else $error("clock ratio decode wrong");
   a_addr8_pins: assert property (inAddr && !wideOp_q |=>
      aleOut && adOut == $past(addr_q[23:8]) && adOe == 16'hffff)
      else $error("8-bit address phase pins wrong");
   a_phase_order: assert property (sAddrEnd |=> sStrobeRun ##1 isIdle)
      else $error("address phase not followed by strobe phase");
   a_data8_pins: assert property (inData && !wideOp_q |=>
      !aleOut && adOut[15:8] == $past(addr_q[7:0]))
      else $error("8-bit data phase upper byte wrong");
   a_wide_write: assert property (inData && wideOp_q && wrOp_q |=>
      !wrN && adOut == $past(wdat_q) && adOe == 16'hffff)
      else $error("16-bit write data phase wrong");
   a_strobe_excl: assert property (!(aleOut && (!rdN || !wrN)) && !(!rdN && !wrN))
      else $error("strobes overlap");
   a_lock_wait: assert property ($rose(pllDone_q) |-> lockCnt_q == 32'(PLL_LOCK))
      else $error("lock released at wrong count");
   a_idle_locked: assert property (!pllDone_q |-> isIdle && rdN && wrN)
      else $error("port active before lock");
endmodule

/* File: verification/mad_mem_model.sv */
`timescale 1ns/100ps
// far side of the muxed pins: address latch and a small parallel memory
module mad_mem_model (
   input  wire logic        clk_sys,
   input  wire logic        wide,
   input  wire logic [15:0] adOut,
   input  wire logic [15:0] adOe,
   input  wire logic        aleOut,
   input  wire logic        rdN,
   input  wire logic        wrN,
   output logic      [15:0] adBus
);
   logic [15:0] latchQ;
   logic [15:0] mem [256];
   logic [7:0]  key;
   logic [15:0] drv;

   // capture while the strobe is high, hold through the data phase
   always_ff @(posedge clk_sys) begin
      if (aleOut) begin
         latchQ <= adBus;
      end
   end

   // in byte mode the low address byte rides on the upper pins
   assign key = wide ? latchQ[7:0] : adOut[15:8];

   // last strobe cycle wins, so a slow device edge is harmless
   always_ff @(posedge clk_sys) begin
      if (!wrN) begin
         mem[key] <= wide ? adBus : {8'h00, adBus[7:0]};
      end
   end

   // released pins float high through their pull-ups
   assign drv   = !rdN ? (wide ? mem[key] : {8'hff, mem[key][7:0]}) : 16'hffff;
   assign adBus = (adOe & adOut) | (~adOe & drv);
endmodule

/* File: verification/muxed_addr_data_pin_control_bench.sv */
`timescale 1ns/100ps
`include "mad_params.svh"
module muxed_addr_data_pin_control_bench;
   typedef struct packed {
      logic [1:0]  r;
      logic [31:0] m;
      logic [31:0] v;
   } mad_note_t;
   logic        clk_sys = 1'b0, rst = 1'b1, wide = 1'b0, aleQ = 1'b0, wrQ = 1'b1;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, rnd = 32'h7f05, rdata;
   logic [1:0]  bootSelectStraps = 2'h0, clockRatioStraps = 2'h0, clkDiv = 2'h0, bresp, rresp;
   logic        inputClockPin = 1'b0, awready, wready, bvalid, arready, rvalid;
   logic        aleOut, rdN, wrN, coreRun;
   logic [15:0] adOut, adOe, adBus;
   logic [23:0] a, ak;
   logic [4:0]  ratioTab [4] = '{5'h03, 5'h10, 5'h08, 5'h00};
   logic [7:0]  dat [16];
   mad_note_t   n;
   mad_note_t   qRd [$];
   logic [1:0]  qB [$];
   logic [15:0] qPin [$];
   int          n_mismatch = 0, checks_done = 0, k;

   mad_port #(.PLL_LOCK(4)) u_dut (
      .clk_sys(clk_sys), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .adIn(adBus), .adOut(adOut), .adOe(adOe), .aleOut(aleOut), .rdN(rdN), .wrN(wrN),
      .bootSelectStraps(bootSelectStraps), .clockRatioStraps(clockRatioStraps),
      .inputClockPin(inputClockPin), .bootMode(), .coreRatio(), .coreRun(coreRun));
   mad_mem_model u_mem (.clk_sys(clk_sys), .wide(wide), .adOut(adOut), .adOe(adOe),
      .aleOut(aleOut), .rdN(rdN), .wrN(wrN), .adBus(adBus));

   always #5 clk_sys = ~clk_sys;
   // slow input clock, phase restarted by reset so the lock count is predictable
   always @(posedge clk_sys) begin
      clkDiv <= rst ? 2'h0 : clkDiv + 2'h1;
      inputClockPin <= clkDiv[1];
   end

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
      checks_done++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic bound(input logic ok);
      if (!ok) begin
         n_mismatch++;
         $display("[ERR] wait expected done seen timeout");
         print_verdict();
      end
   endtask
   task automatic doReset(input logic [1:0] bs, input logic [1:0] cs);
      rst <= 1'b1;
      bootSelectStraps <= bs;
      clockRatioStraps <= cs;
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
   endtask
   // requests change after a rising edge; grants are read at the preceding low phase
   task automatic axw(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
      logic tA, tW, tB;
      int   j;
      tB = 1'b0;
      @(posedge clk_sys);
      qB.push_back(er);
      awaddr <= ad;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (j = 0; j < 400 && !tB; j++) begin
         @(negedge clk_sys);
         tA = awvalid && awready;
         tW = wvalid && wready;
         tB = bvalid;
         @(posedge clk_sys);
         if (tA) awvalid <= 1'b0;
         if (tW) wvalid <= 1'b0;
         if (tB) bready <= 1'b0;
      end
      bound(tB);
   endtask
   task automatic axr(input logic [7:0] ad, input mad_note_t e);
      logic tA, tR;
      int   j;
      tR = 1'b0;
      @(posedge clk_sys);
      qRd.push_back(e);
      araddr <= ad;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (j = 0; j < 400 && !tR; j++) begin
         @(negedge clk_sys);
         tA = arvalid && arready;
         tR = rvalid;
         @(posedge clk_sys);
         if (tA) arvalid <= 1'b0;
         if (tR) rready <= 1'b0;
      end
      bound(tR);
   endtask
   // strobe phases are fixed length, so a short settle covers the tail of a cycle
   task automatic drain;
      int j;
      for (j = 0; j < 3000 && qPin.size() != 0; j++) @(posedge clk_sys);
      bound(qPin.size() == 0);
      repeat (8) @(posedge clk_sys);
   endtask
   task automatic rdBack(input logic [23:0] ad, input logic [15:0] ale, input logic [31:0] e);
      axw(`MAD_OFF_ADDR, {8'h00, ad}, `MAD_RESP_OKAY);
      qPin.push_back(ale);
      axw(`MAD_OFF_RDCMD, 32'h1, `MAD_RESP_OKAY);
      drain();
      axr(`MAD_OFF_RDATA, '{r:`MAD_RESP_OKAY, m:32'hffff_ffff, v:e});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // monitor: each answer, address phase or write data phase takes the oldest note of its kind
   always @(negedge clk_sys) begin
      if (bvalid && bready) chk("write resp", {32'h0, qB.pop_front()}, {32'h0, bresp});
      if (rvalid && rready) begin
         n = qRd.pop_front();
         chk("read word", {n.r, n.v & n.m}, {rresp, rdata & n.m});
      end
      if (aleOut && !aleQ) chk("address phase", {18'h0, qPin.pop_front()}, {18'h0, adOut});
      if (!wrN && wrQ) chk("write data phase", {18'h0, qPin.pop_front()}, {18'h0, adOut});
      aleQ = aleOut;
      wrQ = wrN;
   end

   initial begin
      for (k = 0; k < 3; k++) begin
         doReset(k[1:0], 2'(2 - k));
         axr(`MAD_OFF_STATUS, '{r:`MAD_RESP_OKAY, m:32'hff,
             v:{24'h0, 1'b0, ratioTab[2 - k], k[1:0]}});
      end
      doReset(2'h2, 2'h0);
      repeat (12) @(posedge clk_sys);
      @(negedge clk_sys);
      chk("run before lock", 34'h0, {33'h0, coreRun});
      repeat (8) @(posedge clk_sys);
      @(negedge clk_sys);
      chk("run after lock", 34'h1, {33'h0, coreRun});
      axr(8'h20, '{r:`MAD_RESP_SLVERR, m:32'hffff_ffff, v:32'h0});
      axw(8'h20, rnd, `MAD_RESP_SLVERR);
      $display("test straps and lock done");
      // fill the fifo with the port off, then let it drain in byte mode
      rnd = lfsr(rnd);
      a = rnd[23:0];
      axw(`MAD_OFF_ADDR, {8'h00, a}, `MAD_RESP_OKAY);
      for (k = 0; k < 16; k++) begin
         rnd = lfsr(rnd);
         dat[k] = rnd[7:0];
         ak = a + 24'(k);
         qPin.push_back(ak[23:8]);
         qPin.push_back({ak[7:0], rnd[7:0]});
         axw(`MAD_OFF_WDATA, rnd, `MAD_RESP_OKAY);
      end
      axr(`MAD_OFF_STATUS, '{r:`MAD_RESP_OKAY, m:32'hc00, v:32'h800});
      axw(`MAD_OFF_SYSTEM_CONTROL_REG, 32'h1, `MAD_RESP_OKAY);
      drain();
      axr(`MAD_OFF_STATUS, '{r:`MAD_RESP_OKAY, m:32'hc00, v:32'h400});
      ak = a + 24'h3;
      rdBack(ak, ak[23:8], {24'h0, dat[3]});
      $display("test byte mode done");
      wide <= 1'b1;
      axw(`MAD_OFF_SYSTEM_CONTROL_REG, 32'h3, `MAD_RESP_OKAY);
      rnd = lfsr(rnd);
      a = rnd[23:0];
      axw(`MAD_OFF_ADDR, {8'h00, a}, `MAD_RESP_OKAY);
      rnd = lfsr(rnd);
      qPin.push_back(a[15:0]);
      qPin.push_back(rnd[15:0]);
      axw(`MAD_OFF_WDATA, rnd, `MAD_RESP_OKAY);
      drain();
      rdBack(a, a[15:0], {16'h0, rnd[15:0]});
      $display("test word mode done");
      wide <= 1'b0;
      rnd = lfsr(rnd);
      axw(`MAD_OFF_SYSTEM_CONTROL_REG, 32'h0010_0000, `MAD_RESP_OKAY);
      axw(`MAD_OFF_FLAGS, rnd, `MAD_RESP_OKAY);
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      chk("flag values", {18'h0, rnd[7:0], rnd[15:8]}, {18'h0, adOut});
      chk("flag enables", {18'h0, rnd[23:16], rnd[31:24]}, {18'h0, adOe});
      axr(`MAD_OFF_FLAGIN, '{r:`MAD_RESP_OKAY, m:32'hffff,
          v:{16'h0, rnd[15:0] | ~rnd[31:16]}});
      axw(`MAD_OFF_SYSTEM_CONTROL_REG, 32'h0010_0001, `MAD_RESP_OKAY);
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      chk("enables with port on", 34'h0, {18'h0, adOe});
      $display("test flags done");
      print_verdict();
   end
endmodule
